//--- bench/scrp_sva.sv
// Link checker for the three-wire port between controller and device
`timescale 1ns/1ps
module scrp_sva (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Link
  input wire logic serial_enable_n,
  input wire logic serial_clock_in,
  input wire logic host_data_oe_n,
  input wire logic dev_data_oe_n,
  input wire logic serial_data_io
);
  // ----------------------------------------
  // Frame tracking
  // ----------------------------------------
  logic [4:0] rise_cnt_reg;
  logic       sclk_q_reg;
  logic       dir_reg;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  always_ff @(posedge clock_i) sclk_q_reg <= serial_clock_in;
  always_ff @(posedge clock_i) begin
    if (!resetn_i || serial_enable_n) rise_cnt_reg <= 5'h00;
    else if (serial_clock_in && !sclk_q_reg) rise_cnt_reg <= rise_cnt_reg + 5'h01;
  end
  // Direction bit is the seventh bit on the wire
  always_ff @(posedge clock_i) begin
    if (serial_clock_in && !sclk_q_reg && rise_cnt_reg == 5'h06) dir_reg <= serial_data_io;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_idle_low; serial_enable_n |-> !serial_clock_in; endproperty
  property p_high_8; $rose(serial_clock_in) |-> serial_clock_in [*8] ##1 !serial_clock_in; endproperty
  property p_count_16; $rose(serial_enable_n) |-> rise_cnt_reg == 5'h10; endproperty
  property p_start_drive; $fell(serial_enable_n) |-> !host_data_oe_n; endproperty
  property p_no_clash; !(!host_data_oe_n && !dev_data_oe_n); endproperty
  property p_quiet_idle; serial_enable_n [*8] |-> dev_data_oe_n; endproperty
  property p_dev_start; $fell(dev_data_oe_n) |-> rise_cnt_reg == 5'h08 && !serial_enable_n; endproperty
  property p_read_release; $rose(serial_clock_in) && rise_cnt_reg >= 5'h08 && !dir_reg |-> host_data_oe_n; endproperty
  property p_write_quiet; !serial_enable_n && rise_cnt_reg >= 5'h07 && dir_reg |-> dev_data_oe_n; endproperty
  property p_write_drive; $rose(serial_clock_in) && rise_cnt_reg >= 5'h08 && dir_reg |-> !host_data_oe_n; endproperty

  a_idle_low: assert property (p_idle_low) else $error("link clock runs outside frame");
  a_high_8: assert property (p_high_8) else $error("link clock high phase wrong");
  a_count_16: assert property (p_count_16) else $error("frame not sixteen clocks");
  a_start_drive: assert property (p_start_drive) else $error("controller not driving at frame start");
  a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
  a_quiet_idle: assert property (p_quiet_idle) else $error("device drives between frames");
  a_dev_start: assert property (p_dev_start) else $error("device drives outside data phase");
  a_read_release: assert property (p_read_release) else $error("controller holds data in read");
  a_write_quiet: assert property (p_write_quiet) else $error("device drives during write");
  a_write_drive: assert property (p_write_drive) else $error("controller drops data in write");

  c_write: cover property ($rose(serial_enable_n) && dir_reg);
  c_read: cover property ($rose(serial_enable_n) && !dir_reg);
  c_dev: cover property ($fell(dev_data_oe_n));
endmodule // scrp_sva

//--- bench/serial_config_register_port_tb.sv
// Bench joining controller and device, driven over Wishbone
`timescale 1ns/1ps
module serial_config_register_port_tb;
  import scrp_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clock_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        pmode_n = 1'b1;
  logic        vsync = 1'b1;
  logic        lodd = 1'b0;
  logic        sb, tc, soe, pwm, pen, pauto, den, trn, cft, lao, hs, vertical_sync_in, crst;
  logic [3:0]  pat;
  logic [2:0]  cmap;
  int          errors = 0;
  int          total_checks = 0;
  int          cyc_cnt = 0;
  int          pulses = 0;

  scrp_if link_if ();
  scrp_host scrp_host_i (.clock_i(clock_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .link(link_if));
  scrp_device scrp_device_i (.clock_i(clock_i), .resetn_i(resetn_i), .link(link_if),
    .pin_control_mode_n_i(pmode_n), .pin_standby_n_i(1'b1), .pin_horizontal_shift_dir_i(1'b1),
    .pin_vertical_scan_dir_i(1'b1), .vertical_sync_in_i(vsync), .line_odd_i(lodd), .standby_n_o(sb),
    .timing_controller_en_o(tc), .source_outputs_oe_n_o(soe), .backlight_powerdown_n_o(pwm),
    .test_pattern_select_o(pat), .pattern_enable_o(pen), .pattern_auto_run_o(pauto), .dither_enable_o(den),
    .truncate_lsb_o(trn), .color_filter_type_o(cft), .color_mapping_o(cmap), .line_arrangement_odd_o(lao),
    .horizontal_shift_dir_o(hs), .vertical_scan_dir_o(vertical_sync_in), .chip_reset_o(crst));
  scrp_sva scrp_sva_i (.clock_i(clock_i), .resetn_i(resetn_i), .serial_enable_n(link_if.serial_enable_n),
    .serial_clock_in(link_if.serial_clock_in), .host_data_oe_n(link_if.host_data_oe_n),
    .dev_data_oe_n(link_if.dev_data_oe_n), .serial_data_io(link_if.serial_data_io));

  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc_cnt++;
    if (crst === 1'b1) pulses++;
    if (cyc_cnt == 60000) begin
      errors++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do @(posedge clock_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // One frame on the link, waits until the controller is idle
  task automatic frm(input logic we, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [31:0] r;
    wb(1'b1, SCRP_WB_CMD, 32'({we, 2'b00, a, d}), r);
    do wb(1'b0, SCRP_WB_STATUS, 32'h0, r); while (r[0] !== 1'b0);
    wb(1'b0, SCRP_WB_RDATA, 32'h0, r);
    q = r[7:0];
  endtask
  task automatic vs();
    vsync <= 1'b0;
    repeat (4) @(posedge clock_i);
    vsync <= 1'b1;
    repeat (8) @(posedge clock_i);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [7:0]  q;
    logic [31:0] w;
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk("standby", sb, 1);
    chk("pwm", pwm, 0);
    chk("dither", den, 1);
    chk("line arrangement", lao, 1);
    for (int a = 0; a < 32; a++) begin
      frm(1'b0, 6'(a), 8'h00, q);
      chk("reset value", q, SCRP_RESET_VAL[a]);
    end
    wb(1'b0, 8'h0C, 32'h0, w);
    chk("unmapped bus", w, 0);
    wb(1'b0, SCRP_WB_CMD, 32'h0, w);
    chk("command readback", w, 32'h0000_1F00);
    $display("Reset value test done");
    for (int a = 1; a < 32; a++) begin
      frm(1'b1, 6'(a), 8'hFF, q);
      frm(1'b0, 6'(a), 8'h00, q);
      chk("writable bits", q, SCRP_WR_MASK[a]);
    end
    frm(1'b1, 6'h00, 8'h00, q);
    frm(1'b0, 6'h03, 8'h00, q);
    chk("soft reset", q, 8'h8C);
    frm(1'b0, 6'h00, 8'h00, q);
    chk("reset bit back", q, 8'h03);
    chk("chip reset pulses", pulses, 1);
    $display("Write and soft reset test done");
    for (int p = 0; p < 16; p++) begin
      frm(1'b1, 6'h00, 8'({4'(p), 4'hB}), q);
      vs();
      chk("pattern", pat, p);
      chk("pattern on", pen, p != 0);
      chk("auto run", pauto, p == 15);
    end
    chk("pwm on", pwm, 1);
    frm(1'b1, 6'h00, 8'h09, q);
    chk("standby now", {sb, tc, soe}, 3'b001);
    chk("pattern held", pat, 4'hF);
    frm(1'b1, 6'h01, 8'h1F, q);
    frm(1'b1, 6'h02, 8'h00, q);
    chk("dither held", den, 1);
    vs();
    chk("dither", {den, trn}, 2'b01);
    chk("filter type", {cft, lao}, 2'b10);
    chk("mapping", cmap, 3'h7);
    chk("hshift", hs, 0);
    chk("vscan", vertical_sync_in, 0);
    lodd <= 1'b1;
    repeat (2) @(posedge clock_i);
    chk("odd line", lao, 1);
    $display("Function test done");
    pmode_n <= 1'b0;
    repeat (4) @(posedge clock_i);
    chk("pin mode", {sb, hs, vertical_sync_in}, 3'b111);
    frm(1'b1, 6'h08, 8'h11, q);
    pmode_n <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk("register mode", sb, 0);
    frm(1'b0, 6'h08, 8'h00, q);
    chk("ignored write", q, SCRP_RESET_VAL[8]);
    $display("Pin mode test done");
    finish_test();
  end
endmodule // serial_config_register_port_tb

//--- hdl/scrp_device.sv
// Device end: three-wire target and the configuration register bank behind it
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps

// Behaviour
// - 16-bit frame, MSB first, address then data
// - Bit 9 one writes, zero reads
// - Bit 8 ignored on write, turnaround on read
// - Device only answers, never starts transfers
// - Device drives read data; controller samples rising
// - Controller releases data line through read phases
// - Settings apply at vsync fall; standby, reset immediate
// - Writing zero resets chip; bit self-restores
// - Standby zero turns off outputs, high impedance
// - PWM power-down zero stops PWM; resets zero
// - Test pattern code selects image, F cycles
// - Dither bit zero dithers, one truncates LSBs
// - Stripe type forces odd-line colour arrangement
// - Three-bit colour mapping field
// - Horizontal shift bit sets source output order
// - Vertical scan bit sets gate scan order
// - Twenty 8-bit registers with reset values
// - Active-low enable frames each transaction
// - Data sampled on serial clock rising edge
// - Pin control mode disables serial register path
module scrp_device (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  // Link
  scrp_if.device          link,
  // Dedicated function pins
  input  wire logic       pin_control_mode_n_i,
  input  wire logic       pin_standby_n_i,
  input  wire logic       pin_horizontal_shift_dir_i,
  input  wire logic       pin_vertical_scan_dir_i,
  input  wire logic       vertical_sync_in_i,
  // Display timing (same clock)
  input  wire logic       line_odd_i,
  // Function controls
  output logic            standby_n_o,
  output logic            timing_controller_en_o,
  output logic            source_outputs_oe_n_o,
  output logic            backlight_powerdown_n_o,
  output logic      [3:0] test_pattern_select_o,
  output logic            pattern_enable_o,
  output logic            pattern_auto_run_o,
  output logic            dither_enable_o,
  output logic            truncate_lsb_o,
  output logic            color_filter_type_o,
  output logic      [2:0] color_mapping_o,
  output logic            line_arrangement_odd_o,
  output logic            horizontal_shift_dir_o,
  output logic            vertical_scan_dir_o,
  output logic            chip_reset_o
);
  import scrp_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [2:0]  sclk_sync_reg;
  logic [2:0]  vs_sync_reg;
  logic [1:0]  sen_sync_reg;
  logic [1:0]  sda_sync_reg;
  logic [1:0]  pcm_sync_reg;
  logic [1:0]  stby_sync_reg;
  logic [1:0]  hs_sync_reg;
  logic [1:0]  vsd_sync_reg;

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      sclk_sync_reg <= 3'h0;
      vs_sync_reg   <= 3'h7;
      sen_sync_reg  <= 2'h3;
      sda_sync_reg  <= 2'h3;
      pcm_sync_reg  <= 2'h3;
      stby_sync_reg <= 2'h3;
      hs_sync_reg   <= 2'h3;
      vsd_sync_reg  <= 2'h3;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], link.serial_clock_in};
      vs_sync_reg   <= {vs_sync_reg[1:0], vertical_sync_in_i};
      sen_sync_reg  <= {sen_sync_reg[0], link.serial_enable_n};
      sda_sync_reg  <= {sda_sync_reg[0], link.serial_data_io};
      pcm_sync_reg  <= {pcm_sync_reg[0], pin_control_mode_n_i};
      stby_sync_reg <= {stby_sync_reg[0], pin_standby_n_i};
      hs_sync_reg   <= {hs_sync_reg[0], pin_horizontal_shift_dir_i};
      vsd_sync_reg  <= {vsd_sync_reg[0], pin_vertical_scan_dir_i};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic vsync_fall;
  logic serial_mode;
  logic frame_active;

  assign sclk_rise    = sclk_sync_reg[1] & !sclk_sync_reg[2];
  assign sclk_fall    = !sclk_sync_reg[1] & sclk_sync_reg[2];
  assign vsync_fall   = !vs_sync_reg[1] & vs_sync_reg[2];
  assign serial_mode  = pcm_sync_reg[1];
  assign frame_active = !sen_sync_reg[1] & serial_mode;

  // ----------------------------------------
  // Frame receiver
  // ----------------------------------------
  logic [4:0]  bit_cnt_reg;
  logic [15:0] shift_reg;
  logic        is_read_reg;
  logic [7:0]  rd_byte_reg;
  logic        sdo_reg;
  logic        oe_n_reg;
  logic        soft_rst_reg;
  logic [7:0]  shadow_reg [SCRP_NUM_REGS];
  logic [7:0]  active_reg [SCRP_NUM_REGS];
  logic [5:0]  rx_addr;
  logic [5:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        wr_commit;

  assign rx_addr   = shift_reg[5:0];
  assign wr_addr   = shift_reg[14:9];
  assign wr_data   = {shift_reg[6:0], sda_sync_reg[1]};
  // Bit 8 sits in shift_reg[7] and is never looked at
  assign wr_commit = frame_active & sclk_rise & (bit_cnt_reg == SCRP_CNT_LAST)
                     & shift_reg[SCRP_DIR_BIT - 1];

  always_ff @(posedge clock_i) begin
    if (!resetn_i || !frame_active) begin
      bit_cnt_reg <= 5'h00;
      shift_reg   <= 16'h0000;
    end else if (sclk_rise && bit_cnt_reg != SCRP_CNT_END) begin
      shift_reg   <= {shift_reg[14:0], sda_sync_reg[1]};
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // Read byte is captured once the direction bit arrives
  always_ff @(posedge clock_i) begin
    if (!resetn_i || !frame_active) begin
      is_read_reg <= 1'b0;
      rd_byte_reg <= 8'h00;
      sdo_reg     <= 1'b0;
      oe_n_reg    <= 1'b1;
    end else if (sclk_rise && bit_cnt_reg == SCRP_CNT_DIR) begin
      is_read_reg <= !sda_sync_reg[1];
      rd_byte_reg <= rx_addr[5] ? 8'h00 : shadow_reg[rx_addr[4:0]];
    end else if (sclk_fall && is_read_reg) begin
      if (bit_cnt_reg >= SCRP_CNT_TURN && bit_cnt_reg <= SCRP_CNT_LAST) begin
        oe_n_reg    <= 1'b0;
        sdo_reg     <= rd_byte_reg[7];
        rd_byte_reg <= {rd_byte_reg[6:0], 1'b0};
      end else begin
        oe_n_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr_commit && wr_addr == SCRP_SYSTEM_CONTROL
                      && !wr_data[SCRP_SOFT_RESET_BIT];
    end
  end

  generate
    for (genvar i = 0; i < SCRP_NUM_REGS; i++) begin : g_reg
      // Masks keep unimplemented entries and reserved bits at zero
      always_ff @(posedge clock_i) begin
        if (!resetn_i || soft_rst_reg) begin
          shadow_reg[i] <= SCRP_RESET_VAL[i] & SCRP_WR_MASK[i];
        end else if (wr_commit && wr_addr == 6'(i)) begin
          shadow_reg[i] <= wr_data & SCRP_WR_MASK[i];
        end
      end

      always_ff @(posedge clock_i) begin
        if (!resetn_i || soft_rst_reg) begin
          active_reg[i] <= SCRP_RESET_VAL[i] & SCRP_WR_MASK[i];
        end else if (vsync_fall) begin
          active_reg[i] <= shadow_reg[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Function outputs
  // ----------------------------------------
  logic [7:0] sys_act;
  logic [7:0] tfc_act;
  logic [7:0] opc_act;
  logic       standby_n;

  assign sys_act   = active_reg[SCRP_SYSTEM_CONTROL[4:0]];
  assign tfc_act   = active_reg[SCRP_TIMING_FUNCTION_CTRL[4:0]];
  assign opc_act   = active_reg[SCRP_OPERATION_CONTROL[4:0]];
  assign standby_n = serial_mode ? shadow_reg[SCRP_SYSTEM_CONTROL[4:0]][SCRP_STANDBY_BIT]
                                 : stby_sync_reg[1];

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      standby_n_o             <= 1'b1;
      timing_controller_en_o  <= 1'b1;
      source_outputs_oe_n_o   <= 1'b0;
      backlight_powerdown_n_o <= 1'b0;
      test_pattern_select_o   <= SCRP_PATTERN_OFF;
      pattern_enable_o        <= 1'b0;
      pattern_auto_run_o      <= 1'b0;
      dither_enable_o         <= 1'b1;
      truncate_lsb_o          <= 1'b0;
      color_filter_type_o     <= 1'b0;
      color_mapping_o         <= 3'h0;
      line_arrangement_odd_o  <= 1'b1;
      horizontal_shift_dir_o  <= 1'b1;
      vertical_scan_dir_o     <= 1'b1;
      chip_reset_o            <= 1'b0;
    end else begin
      standby_n_o             <= standby_n;
      timing_controller_en_o  <= standby_n;
      source_outputs_oe_n_o   <= !standby_n;
      backlight_powerdown_n_o <= sys_act[SCRP_PWM_BIT];
      test_pattern_select_o   <= sys_act[SCRP_PATTERN_LSB +: 4];
      pattern_enable_o        <= sys_act[SCRP_PATTERN_LSB +: 4] != SCRP_PATTERN_OFF;
      pattern_auto_run_o      <= sys_act[SCRP_PATTERN_LSB +: 4] == SCRP_PATTERN_AUTO;
      dither_enable_o         <= !tfc_act[SCRP_DITHER_BIT];
      truncate_lsb_o          <= tfc_act[SCRP_DITHER_BIT];
      color_filter_type_o     <= tfc_act[SCRP_CFTYPE_BIT];
      color_mapping_o         <= tfc_act[SCRP_MAP_LSB +: 3];
      line_arrangement_odd_o  <= !tfc_act[SCRP_CFTYPE_BIT] | line_odd_i;
      horizontal_shift_dir_o  <= serial_mode ? opc_act[SCRP_HSHIFT_BIT] : hs_sync_reg[1];
      vertical_scan_dir_o     <= serial_mode ? opc_act[SCRP_VSCAN_BIT] : vsd_sync_reg[1];
      chip_reset_o            <= soft_rst_reg;
    end
  end

  assign link.dev_data      = sdo_reg;
  assign link.dev_data_oe_n = oe_n_reg;

endmodule // scrp_device

//--- hdl/scrp_host.sv
// Controller end: Wishbone slave that runs frames as master on the three-wire link
`timescale 1ns/1ps
module scrp_host (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Link
  scrp_if.host             link
);
  import scrp_pkg::*;

  logic [23:0]  cmd_reg;
  logic         start_reg;
  logic [7:0]   rdata_reg;
  logic [1:0]   sda_sync_reg;
  scrp_hstate_t state_reg;
  logic [7:0]   div_reg;
  logic [3:0]   bit_reg;
  logic [15:0]  frame_reg;
  logic         sclk_reg;
  logic         sen_n_reg;
  logic         sdo_reg;
  logic         oe_n_reg;
  logic         ack_reg;
  logic [31:0]  dat_o_reg;
  logic         wb_req;
  logic         is_write;

  assign wb_req   = wb_cyc_i & wb_stb_i & !ack_reg;
  assign is_write = cmd_reg[SCRP_CMD_WRITE_BIT];

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ack_reg   <= 1'b0;
      dat_o_reg <= 32'h0000_0000;
      cmd_reg   <= 24'h00_0000;
      start_reg <= 1'b0;
    end else begin
      ack_reg   <= wb_req;
      start_reg <= 1'b0;
      if (wb_req && wb_we_i) begin
        if (wb_adr_i == SCRP_WB_CMD && state_reg == SCRP_H_IDLE && !start_reg) begin
          for (int k = 0; k < 3; k++) begin
            if (wb_sel_i[k]) begin
              cmd_reg[k*8 +: 8] <= wb_dat_i[k*8 +: 8];
            end
          end
          start_reg <= 1'b1;
        end
      end else if (wb_req) begin
        if (wb_adr_i == SCRP_WB_CMD) begin
          dat_o_reg <= {8'h00, cmd_reg};
        end else if (wb_adr_i == SCRP_WB_STATUS) begin
          dat_o_reg <= {31'h0000_0000, (state_reg != SCRP_H_IDLE) | start_reg};
        end else if (wb_adr_i == SCRP_WB_RDATA) begin
          dat_o_reg <= {24'h00_0000, rdata_reg};
        end else begin
          dat_o_reg <= 32'h0000_0000;
        end
      end
    end
  end

  // ----------------------------------------
  // Frame engine
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      sda_sync_reg <= 2'h3;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], link.serial_data_io};
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_reg <= SCRP_H_IDLE;
      div_reg   <= 8'h00;
      bit_reg   <= 4'h0;
      frame_reg <= 16'h0000;
      sclk_reg  <= 1'b0;
      sen_n_reg <= 1'b1;
      sdo_reg   <= 1'b0;
      oe_n_reg  <= 1'b1;
      rdata_reg <= 8'h00;
    end else begin
      case (state_reg)
        SCRP_H_IDLE: begin
          if (start_reg) begin
            state_reg <= SCRP_H_RUN;
            frame_reg <= {cmd_reg[SCRP_CMD_ADDR_LSB +: SCRP_ADDR_W], is_write, 1'b0,
                          cmd_reg[SCRP_CMD_DATA_LSB +: SCRP_DATA_W]};
            sdo_reg   <= cmd_reg[SCRP_CMD_ADDR_LSB + SCRP_ADDR_W - 1];
            oe_n_reg  <= 1'b0;
            sen_n_reg <= 1'b0;
            bit_reg   <= 4'hF;
            div_reg   <= 8'h00;
            if (!is_write) begin
              rdata_reg <= 8'h00;
            end
          end
        end
        SCRP_H_RUN: begin
          if (div_reg == SCRP_SCLK_HALF_CYC - 8'h01) begin
            div_reg  <= 8'h00;
            sclk_reg <= !sclk_reg;
            if (!sclk_reg) begin
              if (!is_write && bit_reg < 4'h8) begin
                rdata_reg <= {rdata_reg[6:0], sda_sync_reg[1]};
              end
            end else if (bit_reg == 4'h0) begin
              state_reg <= SCRP_H_GAP;
              sen_n_reg <= 1'b1;
              oe_n_reg  <= 1'b1;
            end else begin
              bit_reg   <= bit_reg - 4'h1;
              frame_reg <= {frame_reg[14:0], 1'b0};
              sdo_reg   <= frame_reg[14];
              oe_n_reg  <= !is_write && bit_reg <= 4'h9;
            end
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
        SCRP_H_GAP: begin
          if (div_reg == SCRP_SCLK_HALF_CYC - 8'h01) begin
            div_reg   <= 8'h00;
            state_reg <= SCRP_H_IDLE;
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
        default: state_reg <= SCRP_H_IDLE;
      endcase
    end
  end

  assign wb_dat_o            = dat_o_reg;
  assign wb_ack_o            = ack_reg;
  assign link.serial_clock_in = sclk_reg;
  assign link.serial_enable_n = sen_n_reg;
  assign link.host_data       = sdo_reg;
  assign link.host_data_oe_n  = oe_n_reg;

endmodule // scrp_host

//--- hdl/scrp_if.sv
// Three-wire link between controller and device, with the shared data wire resolved
`timescale 1ns/1ps
interface scrp_if;
  logic serial_enable_n;
  logic serial_clock_in;
  logic host_data;
  logic host_data_oe_n;
  logic dev_data;
  logic dev_data_oe_n;
  logic serial_data_io;

  // Pull-up when nobody drives
  assign serial_data_io = !host_data_oe_n ? host_data : (!dev_data_oe_n ? dev_data : 1'b1);

  modport host (
    output serial_enable_n, serial_clock_in, host_data, host_data_oe_n,
    input  serial_data_io
  );
  modport device (
    input  serial_enable_n, serial_clock_in, serial_data_io,
    output dev_data, dev_data_oe_n
  );
endinterface

//--- hdl/scrp_pkg.sv
// Constants and types shared by both ends of the serial configuration port
package scrp_pkg;

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int          SCRP_FRAME_BITS   = 16;
  localparam int          SCRP_ADDR_W       = 6;
  localparam int          SCRP_DATA_W       = 8;
  localparam int          SCRP_NUM_REGS     = 32;
  localparam int          SCRP_ADDR_MSB     = 15;
  localparam int          SCRP_DIR_BIT      = 9;
  localparam int          SCRP_TURN_BIT     = 8;
  localparam logic [4:0]  SCRP_CNT_DIR      = 5'h06;
  localparam logic [4:0]  SCRP_CNT_TURN     = 5'h08;
  localparam logic [4:0]  SCRP_CNT_LAST     = 5'h0F;
  localparam logic [4:0]  SCRP_CNT_END      = 5'h10;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [5:0] SCRP_SYSTEM_CONTROL       = 6'h00;
  localparam logic [5:0] SCRP_TIMING_FUNCTION_CTRL = 6'h01;
  localparam logic [5:0] SCRP_OPERATION_CONTROL    = 6'h02;
  localparam logic [5:0] SCRP_INPUT_FORMAT_CONTROL = 6'h03;
  localparam logic [5:0] SCRP_SOURCE_DELAY_CONTROL = 6'h04;
  localparam logic [5:0] SCRP_GATE_DELAY_CONTROL   = 6'h05;
  localparam logic [5:0] SCRP_INTERNAL_FUNC_CTRL   = 6'h07;
  localparam logic [5:0] SCRP_CONTRAST_CONTROL     = 6'h08;
  localparam logic [5:0] SCRP_BRIGHTNESS_CONTROL   = 6'h09;
  localparam logic [5:0] SCRP_RED_BLUE_SUBCONTRAST = 6'h0B;
  localparam logic [5:0] SCRP_RED_SUBBRIGHTNESS    = 6'h0C;
  localparam logic [5:0] SCRP_BLUE_SUBBRIGHTNESS   = 6'h0D;
  localparam logic [5:0] SCRP_COMMON_DC_LEVEL      = 6'h0E;
  localparam logic [5:0] SCRP_COMMON_AC_LEVEL      = 6'h0F;
  localparam logic [5:0] SCRP_GAMMA_LEVEL_2        = 6'h10;
  localparam logic [5:0] SCRP_GAMMA_LEVEL_3_4      = 6'h11;
  localparam logic [5:0] SCRP_GAMMA_LEVEL_5_6      = 6'h12;
  localparam logic [5:0] SCRP_OTP_WRITE_DATA       = 6'h1D;
  localparam logic [5:0] SCRP_OTP_PROGRAM_CONTROL  = 6'h1E;
  localparam logic [5:0] SCRP_OTP_SELECT           = 6'h1F;

  // ----------------------------------------
  // Reset values and writable bits; zero mask means not implemented
  // ----------------------------------------
  localparam logic [7:0] SCRP_RESET_VAL [32] = '{
    8'h03, 8'h00, 8'h03, 8'h8C, 8'h46, 8'h0D, 8'h00, 8'h00,
    8'h08, 8'h40, 8'h00, 8'h88, 8'h20, 8'h20, 8'h2B, 8'hA5,
    8'h04, 8'h24, 8'h24, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] SCRP_WR_MASK [32] = '{
    8'hFB, 8'h1F, 8'h0F, 8'hFF, 8'hFF, 8'h7F, 8'h00, 8'h30,
    8'h1F, 8'h7F, 8'h00, 8'hCC, 8'h3F, 8'h3F, 8'h7F, 8'hFF,
    8'h17, 8'h3F, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h01};

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int         SCRP_SOFT_RESET_BIT = 0;
  localparam int         SCRP_STANDBY_BIT    = 1;
  localparam int         SCRP_PWM_BIT        = 3;
  localparam int         SCRP_PATTERN_LSB    = 4;
  localparam int         SCRP_CFTYPE_BIT     = 0;
  localparam int         SCRP_DITHER_BIT     = 1;
  localparam int         SCRP_MAP_LSB        = 2;
  localparam int         SCRP_HSHIFT_BIT     = 0;
  localparam int         SCRP_VSCAN_BIT      = 1;
  localparam logic [3:0] SCRP_PATTERN_OFF    = 4'h0;
  localparam logic [3:0] SCRP_PATTERN_AUTO   = 4'hF;

  // ----------------------------------------
  // Controller: bus map and link timing
  // ----------------------------------------
  localparam logic [7:0] SCRP_WB_CMD        = 8'h00;
  localparam logic [7:0] SCRP_WB_STATUS     = 8'h04;
  localparam logic [7:0] SCRP_WB_RDATA      = 8'h08;
  localparam int         SCRP_CMD_DATA_LSB  = 0;
  localparam int         SCRP_CMD_ADDR_LSB  = 8;
  localparam int         SCRP_CMD_WRITE_BIT = 16;
  localparam int         SCRP_CLK_PERIOD_NS = 10;
  localparam int         SCRP_SCLK_HALF_NS  = 80;
  localparam logic [7:0] SCRP_SCLK_HALF_CYC = 8'(SCRP_SCLK_HALF_NS / SCRP_CLK_PERIOD_NS);

  typedef enum logic [1:0] {SCRP_H_IDLE, SCRP_H_RUN, SCRP_H_GAP} scrp_hstate_t;

endpackage
